// File: hsar_top.sv
// Contract
// - user alarm bit 5 drives the beep output; cleared at reset.
// - battery alarm enable bit 1 sounds beep on battery limit excursion.
// - standby alarm enable bit 0 sounds beep on standby limit excursion.
// - system temperature reads measured value plus offset at 54h.
// - processor temperature reads measured value plus offset at 55h.
// - status one bits 7,6 show fan count over limit.
// - status one bits 5,4 set on over-temp, clear below hysteresis.
// - status one bits 3..0 show main, analog, input0, core rail faults.
// - status two bits 7,6 warn after three minutes hot at full cruise.
// - status two bit 4 shows a latched chassis intrusion.
// - status two bit 0 shows general input 1 out of range.
// - status three bit 5 shows general input 2 out of range.
// - status three bits 1,0 show battery and standby out of range.
// - value bank holds readings 50h,51h and limits 54h to 57h.
// - battery reading updates only after one full cycle following enable.
// - interrupt status bits 1,0 latch battery and standby excursions.
// - mask bits stop matching status bits raising the management interrupt.
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ns
`include "hsar_regs.svh"

module hsar_top
  import hsar_pkg::*;
#(
  parameter logic [31:0] CRUISE_CYCLES = 32'(`HSAR_CRUISE_CYCLES)
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [12:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [12:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire hsar_mon_flags_t i_mon_flags,
  input wire hsar_cruise_t i_cruise,
  input wire hsar_meas_t i_meas,
  input wire logic i_cycle_done,
  input wire logic i_case_open,
  output logic o_beep,
  output logic o_smi,
  output logic [7:0] o_sys_temp,
  output logic [7:0] o_proc_temp
);

  // reset release
  logic [1:0] rst_sync_ff;
  logic rst_n;
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // software registers
  logic [7:0] alarm_ctrl_ff;
  logic [7:0] sys_offset_ff;
  logic [7:0] proc_offset_ff;
  logic [7:0] int_mask_ff;
  logic [7:0] int_status_ff;
  logic [7:0] mon_ctrl_ff;
  logic [7:0] standby_high_ff;
  logic [7:0] standby_low_ff;
  logic [7:0] battery_high_ff;
  logic [7:0] battery_low_ff;
  logic [7:0] standby_read_ff;
  logic [7:0] battery_read_ff;
  logic [7:0] status_one_ff;
  logic [7:0] status_two_ff;
  logic [7:0] status_three_ff;
  logic [7:0] sys_temp_ff;
  logic [7:0] proc_temp_ff;

  // bus handshake state
  logic awready_ff;
  logic wready_ff;
  logic bvalid_ff;
  logic [1:0] bresp_ff;
  logic arready_ff;
  logic rvalid_ff;
  logic [1:0] rresp_ff;
  logic [31:0] rdata_ff;

  wire wr_take = s_axi_awvalid && s_axi_wvalid && !awready_ff && !bvalid_ff;
  wire wr_fire = awready_ff;
  wire rd_take = s_axi_arvalid && !arready_ff && !rvalid_ff;
  wire rd_fire = arready_ff;

  // write decode, address held by master until awready
  wire [2:0] wr_bank = s_axi_awaddr[`HSAR_BANK_MSB:`HSAR_BANK_LSB];
  wire [7:0] wr_idx = s_axi_awaddr[`HSAR_IDX_MSB:`HSAR_IDX_LSB];
  wire wr_lane = wr_fire && s_axi_wstrb[0];
  wire [7:0] wr_byte = s_axi_wdata[7:0];
  wire wr_bank_alarm = wr_bank == `HSAR_BANK_ALARM;
  wire wr_bank_value = wr_bank == `HSAR_BANK_VALUE;
  wire wr_alarm_ctrl = wr_bank_alarm && wr_idx == `HSAR_IDX_ALARM_CTRL;
  wire wr_sys_offset = wr_bank_alarm && wr_idx == `HSAR_IDX_SYS_OFFSET;
  wire wr_proc_offset = wr_bank_alarm && wr_idx == `HSAR_IDX_PROC_OFFSET;
  wire wr_int_mask = wr_bank_alarm && wr_idx == `HSAR_IDX_INT_MASK;
  wire wr_mon_ctrl = wr_bank == `HSAR_BANK_CFG && wr_idx == `HSAR_IDX_MON_CTRL;
  wire wr_sb_high = wr_bank_value && wr_idx == `HSAR_IDX_STANDBY_HIGH;
  wire wr_sb_low = wr_bank_value && wr_idx == `HSAR_IDX_STANDBY_LOW;
  wire wr_bat_high = wr_bank_value && wr_idx == `HSAR_IDX_BATTERY_HIGH;
  wire wr_bat_low = wr_bank_value && wr_idx == `HSAR_IDX_BATTERY_LOW;
  // read-only registers accept the write silently
  // writes ignored
  wire wr_ro = wr_bank_alarm && (wr_idx == `HSAR_IDX_INT_STATUS
    || wr_idx == `HSAR_IDX_STATUS_ONE || wr_idx == `HSAR_IDX_STATUS_TWO
    || wr_idx == `HSAR_IDX_STATUS_THREE)
    || wr_bank_value && (wr_idx == `HSAR_IDX_STANDBY_READ
    || wr_idx == `HSAR_IDX_BATTERY_READ)
    || wr_bank == `HSAR_BANK_TEMP && (wr_idx == `HSAR_IDX_SYS_TEMP
    || wr_idx == `HSAR_IDX_PROC_TEMP);
  wire wr_hit = wr_alarm_ctrl || wr_sys_offset || wr_proc_offset || wr_int_mask
    || wr_mon_ctrl || wr_sb_high || wr_sb_low || wr_bat_high || wr_bat_low || wr_ro;

  // read decode
  wire [2:0] rd_bank = s_axi_araddr[`HSAR_BANK_MSB:`HSAR_BANK_LSB];
  wire [7:0] rd_idx = s_axi_araddr[`HSAR_IDX_MSB:`HSAR_IDX_LSB];
  wire rd_bank_alarm = rd_bank == `HSAR_BANK_ALARM;
  wire rd_bank_value = rd_bank == `HSAR_BANK_VALUE;
  wire rd_bank_temp = rd_bank == `HSAR_BANK_TEMP;
  wire rd_alarm_ctrl = rd_bank_alarm && rd_idx == `HSAR_IDX_ALARM_CTRL;
  wire rd_sys_offset = rd_bank_alarm && rd_idx == `HSAR_IDX_SYS_OFFSET;
  wire rd_proc_offset = rd_bank_alarm && rd_idx == `HSAR_IDX_PROC_OFFSET;
  wire rd_int_mask = rd_bank_alarm && rd_idx == `HSAR_IDX_INT_MASK;
  wire rd_int_status = rd_bank_alarm && rd_idx == `HSAR_IDX_INT_STATUS;
  wire rd_status_one = rd_bank_alarm && rd_idx == `HSAR_IDX_STATUS_ONE;
  wire rd_status_two = rd_bank_alarm && rd_idx == `HSAR_IDX_STATUS_TWO;
  wire rd_status_three = rd_bank_alarm && rd_idx == `HSAR_IDX_STATUS_THREE;
  wire rd_mon_ctrl = rd_bank == `HSAR_BANK_CFG && rd_idx == `HSAR_IDX_MON_CTRL;
  wire rd_sb_read = rd_bank_value && rd_idx == `HSAR_IDX_STANDBY_READ;
  wire rd_bat_read = rd_bank_value && rd_idx == `HSAR_IDX_BATTERY_READ;
  wire rd_sb_high = rd_bank_value && rd_idx == `HSAR_IDX_STANDBY_HIGH;
  wire rd_sb_low = rd_bank_value && rd_idx == `HSAR_IDX_STANDBY_LOW;
  wire rd_bat_high = rd_bank_value && rd_idx == `HSAR_IDX_BATTERY_HIGH;
  wire rd_bat_low = rd_bank_value && rd_idx == `HSAR_IDX_BATTERY_LOW;
  wire rd_sys_temp = rd_bank_temp && rd_idx == `HSAR_IDX_SYS_TEMP;
  wire rd_proc_temp = rd_bank_temp && rd_idx == `HSAR_IDX_PROC_TEMP;
  wire rd_hit = rd_alarm_ctrl || rd_sys_offset || rd_proc_offset || rd_int_mask
    || rd_int_status || rd_status_one || rd_status_two || rd_status_three
    || rd_mon_ctrl || rd_sb_read || rd_bat_read || rd_sb_high || rd_sb_low
    || rd_bat_high || rd_bat_low || rd_sys_temp || rd_proc_temp;

  wire [7:0] rd_byte =
    rd_alarm_ctrl ? alarm_ctrl_ff :
    rd_sys_offset ? sys_offset_ff :
    rd_proc_offset ? proc_offset_ff :
    rd_int_mask ? int_mask_ff :
    rd_int_status ? int_status_ff :
    rd_status_one ? status_one_ff :
    rd_status_two ? status_two_ff :
    rd_status_three ? status_three_ff :
    rd_mon_ctrl ? mon_ctrl_ff :
    rd_sb_read ? standby_read_ff :
    rd_bat_read ? battery_read_ff :
    rd_sb_high ? standby_high_ff :
    rd_sb_low ? standby_low_ff :
    rd_bat_high ? battery_high_ff :
    rd_bat_low ? battery_low_ff :
    rd_sys_temp ? sys_temp_ff :
    rd_proc_temp ? proc_temp_ff : 8'h00;

  // write channel: both address and data must be present before taking
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `HSAR_RESP_OKAY;
    end else begin
      awready_ff <= wr_take;
      wready_ff <= wr_take;
      if (wr_fire) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_hit ? `HSAR_RESP_OKAY : `HSAR_RESP_SLVERR;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rresp_ff <= `HSAR_RESP_OKAY;
      rdata_ff <= 32'h0000_0000;
    end else begin
      arready_ff <= rd_take;
      if (rd_fire) begin
        rvalid_ff <= 1'b1;
        rresp_ff <= rd_hit ? `HSAR_RESP_OKAY : `HSAR_RESP_SLVERR;
        rdata_ff <= {24'h00_0000, rd_byte};
      end else if (rvalid_ff && s_axi_rready) begin
        rvalid_ff <= 1'b0;
      end
    end
  end

  // control registers
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_ctrl_ff <= `HSAR_RST_ALARM_CTRL;
      sys_offset_ff <= `HSAR_RST_OFFSET;
      proc_offset_ff <= `HSAR_RST_OFFSET;
      int_mask_ff <= `HSAR_RST_INT_MASK;
      mon_ctrl_ff <= 8'h00;
      standby_high_ff <= `HSAR_RST_HIGH_LIMIT;
      standby_low_ff <= `HSAR_RST_LOW_LIMIT;
      battery_high_ff <= `HSAR_RST_HIGH_LIMIT;
      battery_low_ff <= `HSAR_RST_LOW_LIMIT;
    end else if (wr_lane) begin
      if (wr_alarm_ctrl) alarm_ctrl_ff <= wr_byte;
      if (wr_sys_offset) sys_offset_ff <= wr_byte;
      if (wr_proc_offset) proc_offset_ff <= wr_byte;
      if (wr_int_mask) int_mask_ff <= wr_byte;
      if (wr_mon_ctrl) mon_ctrl_ff <= wr_byte;
      if (wr_sb_high) standby_high_ff <= wr_byte;
      if (wr_sb_low) standby_low_ff <= wr_byte;
      if (wr_bat_high) battery_high_ff <= wr_byte;
      if (wr_bat_low) battery_low_ff <= wr_byte;
    end
  end

  wire [7:0] nxt_sys_temp = 8'(i_meas.sys_temp + sys_offset_ff);
  wire [7:0] nxt_proc_temp = 8'(i_meas.proc_temp + proc_offset_ff);

  // standby reading follows the monitor's cycle boundary; temperature readings update every clock
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      sys_temp_ff <= `HSAR_RST_READING;
      proc_temp_ff <= `HSAR_RST_READING;
      standby_read_ff <= `HSAR_RST_READING;
    end else begin
      sys_temp_ff <= nxt_sys_temp;
      proc_temp_ff <= nxt_proc_temp;
      if (i_cycle_done) standby_read_ff <= i_meas.standby;
    end
  end

  // battery: a cycle already running when enabled is partial, so skip it
  hsar_bat_state_t bat_state_ff;
  hsar_bat_state_t nxt_bat_state;
  wire bat_enable = mon_ctrl_ff[`HSAR_BIT_BATTERY_MON];
  always_comb begin
    nxt_bat_state = bat_state_ff;
    unique case (bat_state_ff)
      HSAR_BAT_OFF: begin
        if (bat_enable) nxt_bat_state = HSAR_BAT_PARTIAL;
      end
      HSAR_BAT_PARTIAL: begin
        if (!bat_enable) nxt_bat_state = HSAR_BAT_OFF;
        else if (i_cycle_done) nxt_bat_state = HSAR_BAT_LIVE;
      end
      HSAR_BAT_LIVE: begin
        if (!bat_enable) nxt_bat_state = HSAR_BAT_OFF;
      end
      default: nxt_bat_state = HSAR_BAT_OFF;
    endcase
  end

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      bat_state_ff <= HSAR_BAT_OFF;
      battery_read_ff <= `HSAR_RST_READING;
    end else begin
      bat_state_ff <= nxt_bat_state;
      if (bat_state_ff == HSAR_BAT_LIVE && i_cycle_done) battery_read_ff <= i_meas.battery;
    end
  end

  // limit comparisons; battery only trusted while its monitor is live
  // rail excursions
  wire standby_out = standby_read_ff > standby_high_ff || standby_read_ff < standby_low_ff;
  wire battery_out = bat_state_ff == HSAR_BAT_LIVE
    && (battery_read_ff > battery_high_ff || battery_read_ff < battery_low_ff);

  // chassis intrusion pin: three stages, change counted when 2nd and 3rd agree
  logic [2:0] case_sync_ff;
  logic case_level_ff;
  logic case_latch_ff;
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      case_sync_ff <= 3'h0;
      case_level_ff <= 1'b0;
      case_latch_ff <= 1'b0;
    end else begin
      case_sync_ff <= {case_sync_ff[1:0], i_case_open};
      if (case_sync_ff[1] == case_sync_ff[2]) case_level_ff <= case_sync_ff[2];
      if (case_level_ff) case_latch_ff <= 1'b1;
    end
  end

  // cruise warning timers; long count kept as a parameter for simulation
  logic [1:0] cruise_warn;
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_cruise
      logic [31:0] hot_cnt_ff;
      logic warn_ff;
      wire hot = i_cruise.cruise_mode[g] && i_cruise.above_target[g]
        && i_cruise.full_speed[g];
      always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
          hot_cnt_ff <= 32'h0000_0000;
          warn_ff <= 1'b0;
        end else if (!hot) begin
          hot_cnt_ff <= 32'h0000_0000;
          warn_ff <= 1'b0;
        end else if (hot_cnt_ff >= CRUISE_CYCLES - 32'h0000_0001) begin
          warn_ff <= 1'b1;
        end else begin
          hot_cnt_ff <= hot_cnt_ff + 32'h0000_0001;
        end
      end
      assign cruise_warn[g] = warn_ff;
    end
  endgenerate

  // temperature flags with hysteresis
  logic proc_temp_flag_ff;
  logic sys_temp_flag_ff;
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      proc_temp_flag_ff <= 1'b0;
      sys_temp_flag_ff <= 1'b0;
    end else begin
      if (i_mon_flags.proc_temp_over) proc_temp_flag_ff <= 1'b1;
      else if (i_mon_flags.proc_temp_below_hyst) proc_temp_flag_ff <= 1'b0;
      if (i_mon_flags.sys_temp_over) sys_temp_flag_ff <= 1'b1;
      else if (i_mon_flags.sys_temp_below_hyst) sys_temp_flag_ff <= 1'b0;
    end
  end

  wire [7:0] nxt_status_one = {i_mon_flags.proc_fan_over, i_mon_flags.sys_fan_over,
    proc_temp_flag_ff, sys_temp_flag_ff, i_mon_flags.main_rail_out,
    i_mon_flags.analog_rail_out, i_mon_flags.gen_input0_out, i_mon_flags.core_rail_out};
  wire [7:0] nxt_status_two = {cruise_warn[1], cruise_warn[0], 1'b0, case_latch_ff,
    3'h0, i_mon_flags.gen_input1_out};
  wire [7:0] nxt_status_three = {2'h0, i_mon_flags.gen_input2_out, 3'h0,
    battery_out, standby_out};

  // interrupt status: read clears, a new excursion in that cycle wins
  wire int_rd_clear = rd_fire && rd_int_status;
  wire [1:0] int_events = {battery_out, standby_out};
  wire [7:0] nxt_int_status = {6'h00,
    int_events | (int_rd_clear ? 2'h0 : int_status_ff[1:0])};

  wire nxt_smi = |(int_status_ff[1:0] & ~int_mask_ff[1:0]);
  // beep is OR of the user bit and the enabled battery and standby alarms
  wire nxt_beep = alarm_ctrl_ff[`HSAR_BIT_USER_ALARM]
    || (alarm_ctrl_ff[`HSAR_BIT_BATTERY_ALARM] && battery_out)
    || (alarm_ctrl_ff[`HSAR_BIT_STANDBY_ALARM] && standby_out);

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_one_ff <= 8'h00;
      status_two_ff <= 8'h00;
      status_three_ff <= 8'h00;
      int_status_ff <= 8'h00;
      o_beep <= 1'b0;
      o_smi <= 1'b0;
    end else begin
      status_one_ff <= nxt_status_one;
      status_two_ff <= nxt_status_two;
      status_three_ff <= nxt_status_three;
      int_status_ff <= nxt_int_status;
      o_beep <= nxt_beep;
      o_smi <= nxt_smi;
    end
  end

  assign o_sys_temp = sys_temp_ff;
  assign o_proc_temp = proc_temp_ff;
  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;

endmodule

// File: hsar_regs.svh
`ifndef HSAR_REGS_SVH
`define HSAR_REGS_SVH

// byte address = {bank, index} * 4
`define HSAR_IDX_LSB 2
`define HSAR_IDX_MSB 9
`define HSAR_BANK_LSB 10
`define HSAR_BANK_MSB 12

`define HSAR_BANK_CFG 3'h0
`define HSAR_BANK_ALARM 3'h4
`define HSAR_BANK_VALUE 3'h5
`define HSAR_BANK_TEMP 3'h7

`define HSAR_IDX_MON_CTRL 8'h5D
`define HSAR_IDX_INT_STATUS 8'h50
`define HSAR_IDX_INT_MASK 8'h51
`define HSAR_IDX_ALARM_CTRL 8'h53
`define HSAR_IDX_SYS_OFFSET 8'h54
`define HSAR_IDX_PROC_OFFSET 8'h55
`define HSAR_IDX_STATUS_ONE 8'h59
`define HSAR_IDX_STATUS_TWO 8'h5A
`define HSAR_IDX_STATUS_THREE 8'h5B
`define HSAR_IDX_STANDBY_READ 8'h50
`define HSAR_IDX_BATTERY_READ 8'h51
`define HSAR_IDX_STANDBY_HIGH 8'h54
`define HSAR_IDX_STANDBY_LOW 8'h55
`define HSAR_IDX_BATTERY_HIGH 8'h56
`define HSAR_IDX_BATTERY_LOW 8'h57
`define HSAR_IDX_SYS_TEMP 8'h50
`define HSAR_IDX_PROC_TEMP 8'h51

`define HSAR_BIT_USER_ALARM 5
`define HSAR_BIT_BATTERY_ALARM 1
`define HSAR_BIT_STANDBY_ALARM 0
`define HSAR_BIT_BATTERY_MON 0
`define HSAR_BIT_BATTERY_INT 1
`define HSAR_BIT_STANDBY_INT 0

`define HSAR_RST_ALARM_CTRL 8'h00
`define HSAR_RST_OFFSET 8'h00
`define HSAR_RST_INT_MASK 8'h13
`define HSAR_RST_HIGH_LIMIT 8'hFF
`define HSAR_RST_LOW_LIMIT 8'h00
`define HSAR_RST_READING 8'h00

`define HSAR_CLK_HZ 10000000
`define HSAR_CRUISE_TIME_S 180
`define HSAR_CRUISE_CYCLES (`HSAR_CRUISE_TIME_S * `HSAR_CLK_HZ)

`define HSAR_RESP_OKAY 2'h0
`define HSAR_RESP_SLVERR 2'h2

`endif

// File: hsar_pkg.sv
package hsar_pkg;

  // level conditions from the monitor core, same clock
  typedef struct packed {
    logic proc_fan_over;
    logic sys_fan_over;
    logic proc_temp_over;
    logic proc_temp_below_hyst;
    logic sys_temp_over;
    logic sys_temp_below_hyst;
    logic main_rail_out;
    logic analog_rail_out;
    logic gen_input0_out;
    logic core_rail_out;
    logic gen_input1_out;
    logic gen_input2_out;
  } hsar_mon_flags_t;

  // per-fan automatic cruise conditions, index 1 = processor, 0 = system
  typedef struct packed {
    logic [1:0] cruise_mode;
    logic [1:0] above_target;
    logic [1:0] full_speed;
  } hsar_cruise_t;

  typedef struct packed {
    logic [7:0] sys_temp;
    logic [7:0] proc_temp;
    logic [7:0] standby;
    logic [7:0] battery;
  } hsar_meas_t;

  typedef enum logic [1:0] {
    HSAR_BAT_OFF = 2'b00,
    HSAR_BAT_PARTIAL = 2'b01,
    HSAR_BAT_LIVE = 2'b10
  } hsar_bat_state_t;

endpackage

// File: hsar_top_sva.sv
`timescale 1ns/1ns
`include "hsar_regs.svh"
module hsar_top_sva
  import hsar_pkg::*;
#(
  parameter logic [31:0] CRUISE_CYCLES = 32'h14
) (
  input wire logic i_clk,
  input wire logic i_arst_n,
  input wire logic [12:0] s_axi_awaddr,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire hsar_mon_flags_t i_meas_unused_guard,
  input wire hsar_meas_t i_meas,
  input wire logic o_beep,
  input wire logic [7:0] o_sys_temp,
  input wire logic [7:0] o_proc_temp
);
  logic [2:0] up_ff;
  logic user_ff;
  logic [7:0] soff_ff;
  logic [7:0] poff_ff;
  wire wr_go = s_axi_awready && s_axi_wready && s_axi_wstrb[0];
  wire [10:0] wr_at = s_axi_awaddr[12:2];
  // shadow copies of writable fields, so outputs can be tied to software writes
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      up_ff <= 3'h0;
      user_ff <= 1'b0;
      soff_ff <= 8'h00;
      poff_ff <= 8'h00;
    end else begin
      if (up_ff != 3'h7) up_ff <= up_ff + 3'h1;
      if (wr_go && wr_at == {`HSAR_BANK_ALARM, `HSAR_IDX_ALARM_CTRL}) user_ff <= s_axi_wdata[5];
      if (wr_go && wr_at == {`HSAR_BANK_ALARM, `HSAR_IDX_SYS_OFFSET}) soff_ff <= s_axi_wdata[7:0];
      if (wr_go && wr_at == {`HSAR_BANK_ALARM, `HSAR_IDX_PROC_OFFSET}) poff_ff <= s_axi_wdata[7:0];
    end
  end
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);
  property p_aw_w_pair; s_axi_awready |-> s_axi_wready; endproperty
  a_aw_w_pair: assert property (p_aw_w_pair) else $error("awready without wready");
  property p_wr_resp; s_axi_awready |=> s_axi_bvalid; endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write response late");
  property p_rd_resp; s_axi_arready |=> s_axi_rvalid; endproperty
  a_rd_resp: assert property (p_rd_resp) else $error("read response late");
  property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("write response dropped");
  property p_r_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("read data dropped");
  property p_byte_lane; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
  a_byte_lane: assert property (p_byte_lane) else $error("upper read bytes not zero");
  property p_user_beep; user_ff |=> o_beep; endproperty
  a_user_beep: assert property (p_user_beep) else $error("user beep not driven");
  property p_sys_sum;
    up_ff == 3'h7 |-> o_sys_temp == 8'($past(i_meas.sys_temp) + $past(soff_ff));
  endproperty
  a_sys_sum: assert property (p_sys_sum) else $error("system temperature sum wrong");
  property p_proc_sum;
    up_ff == 3'h7 |-> o_proc_temp == 8'($past(i_meas.proc_temp) + $past(poff_ff));
  endproperty
  a_proc_sum: assert property (p_proc_sum) else $error("processor temperature sum wrong");
  c_user_beep: cover property (user_ff && o_beep);
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == `HSAR_RESP_SLVERR);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
  c_b_stall: cover property (s_axi_bvalid && !s_axi_bready);
endmodule
bind hsar_top hsar_top_sva #(.CRUISE_CYCLES(CRUISE_CYCLES)) sva_u (
  .i_clk(i_clk), .i_arst_n(i_arst_n), .s_axi_awaddr(s_axi_awaddr), .s_axi_wdata(s_axi_wdata),
  .s_axi_wstrb(s_axi_wstrb), .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata), .i_meas_unused_guard(i_mon_flags), .i_meas(i_meas),
  .o_beep(o_beep), .o_sys_temp(o_sys_temp), .o_proc_temp(o_proc_temp));

// File: hsar_top_bench.sv
`timescale 1ns/1ns
`include "hsar_regs.svh"
module hsar_top_bench
  import hsar_pkg::*;
;
  localparam int CRUISE = 20;
  logic i_clk = 1'b0;
  logic i_arst_n = 1'b0;
  logic [12:0] awaddr = 13'h0, araddr = 13'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic awready, wready, bvalid, arready, rvalid, o_beep, o_smi;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] o_sys_temp, o_proc_temp, so, po;
  logic [11:0] f;
  hsar_mon_flags_t mon = '0;
  hsar_cruise_t cru = '0;
  hsar_meas_t meas = '0;
  logic cyc = 1'b0, case_open = 1'b0, stall = 1'b0;
  int fail_count = 0, n_checks = 0;
  integer seed = 32'hEFD87C2A;
  logic [18:0] rst_tab [12] = '{{3'h4, 8'h53, 8'h00}, {3'h4, 8'h54, 8'h00}, {3'h4, 8'h55, 8'h00},
    {3'h4, 8'h59, 8'h00}, {3'h4, 8'h5A, 8'h00}, {3'h4, 8'h5B, 8'h00}, {3'h4, 8'h51, 8'h13},
    {3'h5, 8'h54, 8'hFF}, {3'h5, 8'h55, 8'h00}, {3'h5, 8'h56, 8'hFF}, {3'h5, 8'h57, 8'h00},
    {3'h0, 8'h5D, 8'h00}};
  always #50 i_clk = ~i_clk;
  hsar_top #(.CRUISE_CYCLES(32'(CRUISE))) dut_u (.i_clk(i_clk), .i_arst_n(i_arst_n),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .i_mon_flags(mon), .i_cruise(cru), .i_meas(meas), .i_cycle_done(cyc),
    .i_case_open(case_open), .o_beep(o_beep), .o_smi(o_smi), .o_sys_temp(o_sys_temp),
    .o_proc_temp(o_proc_temp));
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wc(input int n);
    repeat (n) @(posedge i_clk);
  endtask
  task automatic wr(input logic [2:0] b, input logic [7:0] i, input logic [7:0] d,
      input logic [1:0] er);
    awaddr <= {b, i, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= !stall;
    do @(posedge i_clk); while (awready !== 1'b1);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    // late ready: response must hold while stalled
    if (stall) begin
      wc(2);
      bready <= 1'b1;
    end
    do @(posedge i_clk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk(32'(bresp), 32'(er));
    wc(1);
  endtask
  task automatic rd(input logic [2:0] b, input logic [7:0] i, input logic [7:0] e,
      input logic [1:0] er);
    araddr <= {b, i, 2'b00};
    arvalid <= 1'b1;
    rready <= !stall;
    do @(posedge i_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    if (stall) begin
      wc(2);
      rready <= 1'b1;
    end
    do @(posedge i_clk); while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, {24'h0, e});
    chk(32'(rresp), 32'(er));
    wc(1);
  endtask
  task automatic pulse;
    cyc <= 1'b1;
    wc(1);
    cyc <= 1'b0;
    wc(3);
  endtask
  initial begin
    wc(20000);
    fail_count++;
    end_sim();
  end
  initial begin
    wc(5);
    i_arst_n <= 1'b1;
    wc(3);
    foreach (rst_tab[k]) rd(rst_tab[k][18:16], rst_tab[k][15:8], rst_tab[k][7:0], 2'h0);
    rd(3'h4, 8'h56, 8'h00, `HSAR_RESP_SLVERR);
    wr(3'h5, 8'h52, 8'h5A, `HSAR_RESP_SLVERR);
    stall = 1'b1;
    wr(3'h4, 8'h59, 8'hFF, `HSAR_RESP_OKAY);
    rd(3'h4, 8'h59, 8'h00, `HSAR_RESP_OKAY);
    stall = 1'b0;
    wr(3'h4, 8'h53, 8'h20, 2'h0);
    chk(32'(o_beep), 32'h1);
    wr(3'h4, 8'h53, 8'h00, 2'h0);
    chk(32'(o_beep), 32'h0);
    for (int k = 0; k < 4; k++) begin
      so = (k == 0) ? 8'hFF : 8'($random(seed));
      po = 8'($random(seed));
      meas <= 32'($random(seed));
      wr(3'h4, 8'h54, so, 2'h0);
      wr(3'h4, 8'h55, po, 2'h0);
      rd(3'h7, 8'h50, 8'(meas.sys_temp + so), 2'h0);
      rd(3'h7, 8'h51, 8'(meas.proc_temp + po), 2'h0);
      chk(32'(o_sys_temp), 32'(8'(meas.sys_temp + so)));
      chk(32'(o_proc_temp), 32'(8'(meas.proc_temp + po)));
    end
    for (int k = 0; k < 6; k++) begin
      f = 12'($random(seed)) & 12'hC3F;
      mon <= hsar_mon_flags_t'(f);
      wc(3);
      rd(3'h4, 8'h59, {f[11:10], 2'b00, f[5:2]}, 2'h0);
      rd(3'h4, 8'h5A, {7'h0, f[1]}, 2'h0);
      rd(3'h4, 8'h5B, {2'b00, f[0], 5'h0}, 2'h0);
    end
    mon <= hsar_mon_flags_t'(12'h280);
    wc(4);
    rd(3'h4, 8'h59, 8'h30, 2'h0);
    mon <= '0;
    wc(4);
    rd(3'h4, 8'h59, 8'h30, 2'h0);
    mon <= hsar_mon_flags_t'(12'h140);
    wc(4);
    rd(3'h4, 8'h59, 8'h00, 2'h0);
    meas.standby <= 8'h90;
    meas.battery <= 8'h30;
    wr(3'h5, 8'h54, 8'h80, 2'h0);
    wr(3'h5, 8'h55, 8'h40, 2'h0);
    pulse();
    rd(3'h5, 8'h50, 8'h90, 2'h0);
    rd(3'h4, 8'h5B, 8'h01, 2'h0);
    chk(32'(o_beep), 32'h0);
    wr(3'h4, 8'h53, 8'h01, 2'h0);
    chk(32'(o_beep), 32'h1);
    rd(3'h4, 8'h50, 8'h01, 2'h0);
    chk(32'(o_smi), 32'h0);
    wr(3'h4, 8'h51, 8'h00, 2'h0);
    wc(3);
    chk(32'(o_smi), 32'h1);
    wr(3'h4, 8'h51, 8'h01, 2'h0);
    wc(3);
    chk(32'(o_smi), 32'h0);
    wr(3'h0, 8'h5D, 8'h01, 2'h0);
    pulse();
    rd(3'h5, 8'h51, 8'h00, 2'h0);
    pulse();
    rd(3'h5, 8'h51, 8'h30, 2'h0);
    wr(3'h5, 8'h56, 8'h20, 2'h0);
    rd(3'h4, 8'h5B, 8'h03, 2'h0);
    rd(3'h4, 8'h50, 8'h03, 2'h0);
    chk(32'(o_smi), 32'h1);
    wr(3'h4, 8'h53, 8'h02, 2'h0);
    chk(32'(o_beep), 32'h1);
    wr(3'h4, 8'h53, 8'h00, 2'h0);
    chk(32'(o_beep), 32'h0);
    case_open <= 1'b1;
    wc(8);
    case_open <= 1'b0;
    wc(8);
    rd(3'h4, 8'h5A, 8'h10, 2'h0);
    cru <= '1;
    wc(CRUISE - 10);
    rd(3'h4, 8'h5A, 8'h10, 2'h0);
    wc(12);
    rd(3'h4, 8'h5A, 8'hD0, 2'h0);
    cru <= '0;
    wc(4);
    rd(3'h4, 8'h5A, 8'h10, 2'h0);
    end_sim();
  end
endmodule
